// ---- core/wdt_core.sv ----
// watchdog timer with apb register access and interrupt outputs
//
// Behaviour
// - free-running divider chain on selected clock; selected tap sets the time-out
// - writing one to restart_bit zeroes the count; bit clears itself
// - interval select sits in bits 7:6 of clock_control_reg
// - select 00,01,10,11 gives 64, 512, 8192, 32768 clocks
// - after reset interval select is 00, the 64-clock time-out
// - each elapsed interval sets timeout_flag, bit 3 of guard_control_reg
// - counting goes on; with reset_enable and no restart, reset after 512 clocks
// - watchdog reset lasts two machine cycles and sets reset_cause_flag
// - guard interrupt needs timeout_flag, its own enable and global_irq_enable
// - interrupt path and reset path work independently of each other
// - with both disabled the flag is still set at every interval
// - reset_enable, timeout_flag and restart_bit writes need timed access
// - guard_clock_select in config_byte_zero bit 7 picks rc or system clock
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module wdt_core
	import wdt_pkg::*;
#(
	parameter int MC_CLKS = WDT_MC_CLKS
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic unlockPulse,
	input wire logic rcClkPin,
	output logic guardIrq,
	output logic irq,
	output logic sysReset
);

	// ------------------------------------------------------------
	// local widths
	// ------------------------------------------------------------
	localparam int RST_CLKS = WDT_RST_MC * MC_CLKS;
	localparam int RST_W = $clog2(RST_CLKS + 1);
	localparam logic [RST_W-1:0] RST_LAST = RST_W'(RST_CLKS - 1);

	wdt_apb_req_t req;
	wdt_guard_t guardQ;
	wdt_state_t stateQ;
	logic [1:0] selQ;
	logic clkSelQ;
	logic gieQ;
	logic unlockQ;
	logic restartQ;
	logic [WDT_NEV-1:0] statQ;
	logic [WDT_NEV-1:0] maskQ;
	logic [WDT_NEV-1:0] events;
	logic [WDT_DIV_W-1:0] divQ;
	logic [WDT_DIV_W-1:0] tapMask;
	logic [WDT_POST_W-1:0] postQ;
	logic [RST_W-1:0] rstCntQ;
	logic rcSync1Q;
	logic rcSync2Q;
	logic rcPrevQ;
	logic tick;
	logic timeout;
	logic fire;
	logic setup;
	logic access;
	logic wrAcc;
	logic rdAcc;
	logic guardWr;
	logic protOk;
	logic mapped;
	logic [31:0] rdMux;

	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	assign setup = req.sel && !req.enable;
	assign access = req.sel && req.enable && pready;
	assign wrAcc = access && req.write;
	assign rdAcc = access && !req.write;
	assign guardWr = wrAcc && (req.addr == WDT_OFS_GUARD);
	assign protOk = guardWr && (unlockQ || unlockPulse);

	always_comb begin
		mapped = 1'b1;
		rdMux = '0;
		case (req.addr)
			WDT_OFS_GUARD: begin
				rdMux[WDT_B_IRQEN] = guardQ.irqEnable;
				rdMux[WDT_B_RSTEN] = guardQ.resetEnable;
				rdMux[WDT_B_CAUSE] = guardQ.resetCauseFlag;
				rdMux[WDT_B_TOFLAG] = guardQ.timeoutFlag;
			end
			WDT_OFS_CLKCTL: begin
				rdMux[WDT_B_SELHI:WDT_B_SELLO] = selQ;
			end
			WDT_OFS_CFG0: begin
				rdMux[WDT_B_CLKSEL] = clkSelQ;
			end
			WDT_OFS_GLOBAL: begin
				rdMux[WDT_B_GIE] = gieQ;
			end
			WDT_OFS_IRQSTAT: begin
				rdMux[WDT_NEV-1:0] = statQ;
			end
			WDT_OFS_IRQMASK: begin
				rdMux[WDT_NEV-1:0] = maskQ;
			end
			WDT_OFS_COUNT: begin
				rdMux[WDT_DIV_W-1:0] = divQ;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// read data and response are settled in the setup cycle so pready comes from a flop
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clkEn) begin
			if (setup) begin
				prdata <= req.write ? 32'h0000_0000 : rdMux;
				pready <= 1'b1;
				pslverr <= !mapped;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// timed access gate
	// ------------------------------------------------------------
	// unlock stays armed until the next completed write so a slow bus still gets through
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			unlockQ <= 1'b0;
		end else if (clkEn) begin
			if (wrAcc) begin
				unlockQ <= 1'b0;
			end else if (unlockPulse) begin
				unlockQ <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			selQ <= WDT_SEL_RST;
			clkSelQ <= WDT_CLKSEL_RST;
			gieQ <= 1'b0;
			maskQ <= '0;
		end else if (clkEn && wrAcc) begin
			case (req.addr)
				WDT_OFS_CLKCTL: begin
					selQ <= req.wdata[WDT_B_SELHI:WDT_B_SELLO];
				end
				WDT_OFS_CFG0: begin
					clkSelQ <= req.wdata[WDT_B_CLKSEL];
				end
				WDT_OFS_GLOBAL: begin
					gieQ <= req.wdata[WDT_B_GIE];
				end
				WDT_OFS_IRQMASK: begin
					maskQ <= req.wdata[WDT_NEV-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// guard control register
	// ------------------------------------------------------------
	// hardware set wins over a clearing write in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			guardQ <= '0;
		end else if (clkEn) begin
			if (guardWr) begin
				guardQ.irqEnable <= req.wdata[WDT_B_IRQEN];
				if (!req.wdata[WDT_B_CAUSE]) begin
					guardQ.resetCauseFlag <= 1'b0;
				end
			end
			if (protOk) begin
				guardQ.resetEnable <= req.wdata[WDT_B_RSTEN];
				if (!req.wdata[WDT_B_TOFLAG]) begin
					guardQ.timeoutFlag <= 1'b0;
				end
			end
			if (timeout) begin
				guardQ.timeoutFlag <= 1'b1;
			end
			if (fire) begin
				guardQ.resetCauseFlag <= 1'b1;
			end
		end
	end

	// restart pulse lasts one cycle and never reads back
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			restartQ <= 1'b0;
		end else if (clkEn) begin
			restartQ <= protOk && req.wdata[WDT_B_RESTART];
		end
	end

	// ------------------------------------------------------------
	// clock source
	// ------------------------------------------------------------
	// the rc clock is slow and foreign, so it is sampled and each rising edge is one tick
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rcSync1Q <= 1'b0;
			rcSync2Q <= 1'b0;
			rcPrevQ <= 1'b0;
		end else if (clkEn) begin
			rcSync1Q <= rcClkPin;
			rcSync2Q <= rcSync1Q;
			rcPrevQ <= rcSync2Q;
		end
	end

	assign tick = clkSelQ ? (rcSync2Q && !rcPrevQ) : 1'b1;

	// ------------------------------------------------------------
	// divider chain
	// ------------------------------------------------------------
	always_comb begin
		case (wdt_sel_t'(selQ))
			WDT_SEL_64: tapMask = WDT_DIV_W'((1 << WDT_TAP_64) - 1);
			WDT_SEL_512: tapMask = WDT_DIV_W'((1 << WDT_TAP_512) - 1);
			WDT_SEL_8192: tapMask = WDT_DIV_W'((1 << WDT_TAP_8192) - 1);
			WDT_SEL_32768: tapMask = WDT_DIV_W'((1 << WDT_TAP_32768) - 1);
			default: tapMask = WDT_DIV_W'((1 << WDT_TAP_64) - 1);
		endcase
	end

	assign timeout = tick && !restartQ && ((divQ & tapMask) == tapMask);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			divQ <= '0;
		end else if (clkEn) begin
			if (restartQ) begin
				divQ <= '0;
			end else if (tick) begin
				divQ <= divQ + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// grace period and reset sequencer
	// ------------------------------------------------------------
	// the grace count runs even with reset disabled, so enabling late still resets on time
	assign fire = (stateQ == WDT_ST_GRACE) && tick && !restartQ
		&& (postQ == WDT_POST_LAST) && guardQ.resetEnable;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stateQ <= WDT_ST_COUNT;
			postQ <= '0;
			rstCntQ <= '0;
		end else if (clkEn) begin
			case (stateQ)
				WDT_ST_COUNT: begin
					postQ <= '0;
					if (timeout) begin
						stateQ <= WDT_ST_GRACE;
					end
				end
				WDT_ST_GRACE: begin
					if (restartQ) begin
						stateQ <= WDT_ST_COUNT;
					end else if (fire) begin
						stateQ <= WDT_ST_RESET;
						rstCntQ <= '0;
					end else if (tick) begin
						if (postQ == WDT_POST_LAST) begin
							stateQ <= WDT_ST_COUNT;
						end
						postQ <= postQ + 1'b1;
					end
				end
				WDT_ST_RESET: begin
					if (rstCntQ == RST_LAST) begin
						stateQ <= WDT_ST_COUNT;
					end else begin
						rstCntQ <= rstCntQ + 1'b1;
					end
				end
				default: begin
					stateQ <= WDT_ST_COUNT;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sysReset <= 1'b0;
		end else if (clkEn) begin
			if (fire) begin
				sysReset <= 1'b1;
			end else if (stateQ == WDT_ST_RESET && rstCntQ == RST_LAST) begin
				sysReset <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	assign events[WDT_B_EVTO] = timeout;
	assign events[WDT_B_EVRST] = fire;

	genvar gi;
	generate
		for (gi = 0; gi < WDT_NEV; gi++) begin : gEvent
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					statQ[gi] <= 1'b0;
				end else if (clkEn) begin
					if (events[gi]) begin
						statQ[gi] <= 1'b1;
					end else if (rdAcc && req.addr == WDT_OFS_IRQSTAT && prdata[gi]) begin
						statQ[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
			guardIrq <= 1'b0;
		end else if (clkEn) begin
			irq <= |(statQ & maskQ);
			guardIrq <= guardQ.timeoutFlag && guardQ.irqEnable && gieQ;
		end
	end

endmodule : wdt_core

`default_nettype wire

// ---- core/wdt_pkg.sv ----
// shared constants and types of the watchdog timer block
package wdt_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the apb bus
	// ------------------------------------------------------------
	localparam logic [7:0] WDT_OFS_GUARD = 8'h00;
	localparam logic [7:0] WDT_OFS_CLKCTL = 8'h04;
	localparam logic [7:0] WDT_OFS_CFG0 = 8'h08;
	localparam logic [7:0] WDT_OFS_GLOBAL = 8'h0c;
	localparam logic [7:0] WDT_OFS_IRQSTAT = 8'h10;
	localparam logic [7:0] WDT_OFS_IRQMASK = 8'h14;
	localparam logic [7:0] WDT_OFS_COUNT = 8'h18;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int WDT_B_IRQEN = 0;
	localparam int WDT_B_RSTEN = 1;
	localparam int WDT_B_CAUSE = 2;
	localparam int WDT_B_TOFLAG = 3;
	localparam int WDT_B_RESTART = 4;
	localparam int WDT_B_SELLO = 6;
	localparam int WDT_B_SELHI = 7;
	localparam int WDT_B_CLKSEL = 7;
	localparam int WDT_B_GIE = 0;
	localparam int WDT_B_EVTO = 0;
	localparam int WDT_B_EVRST = 1;
	localparam int WDT_NEV = 2;

	// ------------------------------------------------------------
	// divider taps and timing
	// ------------------------------------------------------------
	localparam int WDT_DIV_W = 15;
	localparam int WDT_TAP_64 = 6;
	localparam int WDT_TAP_512 = 9;
	localparam int WDT_TAP_8192 = 13;
	localparam int WDT_TAP_32768 = 15;
	localparam int WDT_POST_W = 9;
	localparam logic [8:0] WDT_POST_LAST = 9'h1ff;
	localparam int WDT_RST_MC = 2;
	localparam int WDT_MC_CLKS = 12;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [1:0] WDT_SEL_RST = 2'h0;
	localparam logic WDT_CLKSEL_RST = 1'h0;

	typedef enum logic [1:0] {
		WDT_SEL_64 = 2'b00,
		WDT_SEL_512 = 2'b01,
		WDT_SEL_8192 = 2'b10,
		WDT_SEL_32768 = 2'b11
	} wdt_sel_t;

	typedef enum logic [1:0] {
		WDT_ST_COUNT = 2'b00,
		WDT_ST_GRACE = 2'b01,
		WDT_ST_RESET = 2'b10
	} wdt_state_t;

	// control bits held in the guard control register
	typedef struct packed {
		logic timeoutFlag;
		logic resetCauseFlag;
		logic resetEnable;
		logic irqEnable;
	} wdt_guard_t;

	// one apb request as the slave sees it
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} wdt_apb_req_t;

endpackage : wdt_pkg

// ---- dv/wdt_core_properties.sv ----
// port assertions of the watchdog timer
`timescale 1ns/100ps
`default_nettype none

module wdt_core_properties #(
	parameter int MC_CLKS = 12
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sysReset
);
	// ------------------------------------------------------------
	// helper: length of the reset pulse
	// ------------------------------------------------------------
	logic [7:0] hiCnt_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			hiCnt_q <= 8'h00;
		else if (sysReset)
			hiCnt_q <= hiCnt_q + 8'h01;
		else
			hiCnt_q <= 8'h00;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence setupS;
		psel && !penable && clkEn;
	endsequence
	sequence mappedS;
		paddr <= 8'h18 && paddr[1:0] == 2'h0;
	endsequence

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	ready_after_setup_a: assert property (setupS |=> pready)
		else $error("no pready after setup");
	ready_one_cycle_a: assert property (pready && clkEn |=> !pready)
		else $error("pready held too long");
	ready_has_cause_a: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
		else $error("pready without setup");
	err_unmapped_a: assert property (setupS ##0 (paddr > 8'h18) |=> pslverr && pready)
		else $error("unmapped access not refused");
	err_mapped_a: assert property (setupS ##0 mappedS |=> !pslverr)
		else $error("mapped access refused");
	write_data_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data on a write");
	reset_width_a: assert property ($fell(sysReset) |-> hiCnt_q == 8'(2 * MC_CLKS))
		else $error("reset pulse length wrong");
	reset_quiet_a: assert property ($fell(sysReset) |=> !sysReset [*8])
		else $error("reset came back too soon");
endmodule : wdt_core_properties

bind wdt_core wdt_core_properties #(.MC_CLKS(MC_CLKS)) props (.mclk(mclk), .rstn(rstn),
	.clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .sysReset(sysReset));

`default_nettype wire

// ---- dv/wdt_partner.sv ----
// far side model: rc oscillator and system reset monitor
`timescale 1ns/100ps
`default_nettype none

module wdt_partner (
	input wire logic mclk,
	input wire logic sysReset,
	output logic rcClkPin,
	output int lastWidth
);
	int hiCnt = 0;
	initial rcClkPin = 1'b0;
	initial lastWidth = 0;
	// rc source runs free, four times slower than mclk so the choice shows
	always #20 rcClkPin = ~rcClkPin;
	// only measures the pulse; resetting the block would wipe the cause flag
	always @(posedge mclk) begin
		if (sysReset === 1'b1)
			hiCnt <= hiCnt + 1;
		else if (hiCnt != 0) begin
			lastWidth <= hiCnt;
			hiCnt <= 0;
		end
	end
endmodule : wdt_partner

`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench of the watchdog timer
`timescale 1ns/100ps
`default_nettype none

module tb
	import wdt_pkg::*;
;
	logic mclk = 0, rstn = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0, unlockPulse = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdVal;
	logic pready, pslverr, errVal, guardIrq, irq, sysReset, rcClkPin;
	int miscompares = 0, total_checks = 0, rstWidth;

	always #5 mclk = ~mclk;

	wdt_core #(.MC_CLKS(2)) dut (.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .unlockPulse(unlockPulse), .rcClkPin(rcClkPin),
		.guardIrq(guardIrq), .irq(irq), .sysReset(sysReset));
	wdt_partner far (.mclk(mclk), .sysReset(sysReset), .rcClkPin(rcClkPin),
		.lastWidth(rstWidth));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	// waits for pready without assuming a latency; only the watchdog ends a wait
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdVal = prdata;
		errVal = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task guard_wr(input logic [31:0] d);
		unlockPulse <= 1'b1;
		@(posedge mclk);
		unlockPulse <= 1'b0;
		apb(1'b1, WDT_OFS_GUARD, d);
	endtask : guard_wr

	task close_out;
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		apb(1'b0, WDT_OFS_CLKCTL, 32'h0);
		chk(rdVal, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, errVal}, 32'h1);
		$display("t_reset done");
	endtask : t_reset

	task t_interval;
		int lens[4] = '{64, 512, 8192, 32768};
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, WDT_OFS_CLKCTL, 32'(s) << WDT_B_SELLO);
			guard_wr(32'h10);
			cyc(lens[s] - 12);
			apb(1'b0, WDT_OFS_GUARD, 32'h0);
			chk(rdVal & 32'h18, 32'h0);
			cyc(20);
			apb(1'b0, WDT_OFS_GUARD, 32'h0);
			chk(rdVal & 32'h8, 32'h8);
		end
		$display("t_interval done");
	endtask : t_interval

	task t_gate;
		apb(1'b1, WDT_OFS_CLKCTL, 32'h0);
		guard_wr(32'h10);
		apb(1'b1, WDT_OFS_GUARD, 32'h2);
		cyc(80);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'ha, 32'h8);
		apb(1'b1, WDT_OFS_GUARD, 32'h0);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'h8, 32'h8);
		guard_wr(32'h0);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'h8, 32'h0);
		cyc(70);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'h8, 32'h8);
		$display("t_gate done");
	endtask : t_gate

	task t_irq;
		apb(1'b1, WDT_OFS_GLOBAL, 32'h1);
		apb(1'b1, WDT_OFS_IRQMASK, 32'h1);
		guard_wr(32'h11);
		cyc(80);
		chk({31'h0, guardIrq}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, WDT_OFS_GLOBAL, 32'h0);
		cyc(2);
		chk({31'h0, guardIrq}, 32'h0);
		apb(1'b0, WDT_OFS_IRQSTAT, 32'h0);
		chk(rdVal & 32'h3, 32'h1);
		apb(1'b0, WDT_OFS_IRQSTAT, 32'h0);
		chk(rdVal & 32'h3, 32'h0);
		cyc(1);
		chk({31'h0, irq}, 32'h0);
		chk(32'(rstWidth), 32'h0);
		$display("t_irq done");
	endtask : t_irq

	task t_wdreset;
		guard_wr(32'h12);
		cyc(560);
		chk({31'h0, sysReset}, 32'h0);
		cyc(40);
		chk(32'(rstWidth), 32'h4);
		chk({31'h0, guardIrq}, 32'h0);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'h6, 32'h6);
		apb(1'b0, WDT_OFS_IRQSTAT, 32'h0);
		chk(rdVal & 32'h2, 32'h2);
		apb(1'b1, WDT_OFS_GUARD, 32'h0);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'h6, 32'h2);
		guard_wr(32'h0);
		$display("t_wdreset done");
	endtask : t_wdreset

	// ten frozen edges between two count reads leave only the three running ones
	task t_freeze;
		logic [31:0] first;
		apb(1'b0, WDT_OFS_COUNT, 32'h0);
		first = rdVal;
		clkEn <= 1'b0;
		cyc(10);
		clkEn <= 1'b1;
		apb(1'b0, WDT_OFS_COUNT, 32'h0);
		chk((rdVal - first) & 32'h7fff, 32'h3);
		$display("t_freeze done");
	endtask : t_freeze

	task t_rcclk;
		apb(1'b1, WDT_OFS_CFG0, 32'h80);
		guard_wr(32'h10);
		cyc(120);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'h8, 32'h0);
		cyc(200);
		apb(1'b0, WDT_OFS_GUARD, 32'h0);
		chk(rdVal & 32'h8, 32'h8);
		$display("t_rcclk done");
	endtask : t_rcclk

	initial begin
		cyc(3);
		rstn <= 1'b1;
		@(posedge mclk);
		t_reset;
		t_interval;
		t_gate;
		t_irq;
		t_wdreset;
		t_freeze;
		t_rcclk;
		close_out;
	end

	initial begin
		#1000000;
		miscompares++;
		close_out;
	end
endmodule : tb

`default_nettype wire
